//--- core/coh_handshake.sv
// Purpose: coprocessor side of the operand transfer handshake
// Assumes: host keeps its own sequencing; inputs synchronous to clk_sys
// Notes: arithmetic is absent; accumulators only hold operands
//
// Summary of operation
// RULE1: host routes an instruction here only when its top four bits are octal 17.
// RULE2: host loads the pending instruction first, then pulses start.
// RULE3: host copies destination general register into input data register first.
// RULE4: instruction decoded and first specific state entered when start arrives.
// RULE5: load: raise sync while waiting for the first operand word.
// RULE6: host starts an operand bus cycle only after sync is seen.
// RULE7: host drives strobe and data together at phase three.
// RULE8: first load word goes into the top quarter of the temporary accumulator.
// RULE9: each further load word goes into the next lower quarter.
// RULE10: host runs another bus cycle only while request stays asserted.
// RULE11: after the last load word, copy temporary into destination accumulator.
// RULE12: single precision moves two words, double precision four.
// RULE13: store: at phase one raise sync, latch top destination word.
// RULE14: host reads the output buffer, then writes the word to memory.
// RULE15: each store strobe clocks the next lower word into the buffer.
// RULE16: drop request once the last word of the precision is handed over.
// RULE17: last single store strobe still latches the third word, never read.
// RULE18: host may copy condition codes, then fetches the next instruction.
// RULE19: direction is set by class: load inward, store outward.
// RULE20: host loops while sync is absent.
// RULE21: initialize pulse clears the major registers.
// RULE22: after initialize, sync and request low and idle until start.
// RULE23: each strobe is one event, advancing the transfer by one word.
module coh_handshake
  import coh_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic init_pulse,
  input wire logic instr_load,
  input wire logic [WORD_W-1:0] instr_word,
  input wire logic gr_load,
  input wire logic [WORD_W-1:0] gr_word,
  input wire logic instr_start_strobe,
  input wire logic word_transfer_strobe,
  input wire logic [WORD_W-1:0] load_data,
  input wire logic double_precision,
  input wire logic host_read_ready,
  output logic coproc_ready_sync,
  output logic more_words_request,
  output logic dir_to_memory,
  output logic out_valid,
  output logic [WORD_W-1:0] data_out_mux,
  output logic [WORD_W-1:0] input_data_reg,
  output logic busy
);
  coh_state_t state, next_state;
  logic [WORD_W-1:0] pending_instr_reg, next_pending_instr_reg;
  logic [WORD_W-1:0] next_input_data_reg;
  logic [ACC_W-1:0] temporary_accumulator, next_temporary_accumulator;
  logic [ACC_W-1:0] destination_accumulator [ACC_NUM];
  logic [ACC_W-1:0] next_destination_accumulator [ACC_NUM];
  logic [ACC_SEL_W-1:0] acc_sel, next_acc_sel;
  logic [1:0] quarter, next_quarter;
  logic [2:0] words_left, next_words_left;
  logic next_sync, next_req, next_dir;
  logic strobe_q;
  logic strobe_evt;
  logic buf_in_valid, buf_in_ready;
  logic [WORD_W-1:0] buf_in_data;
  logic [WORD_W-1:0] out_word_q;
  logic buf_out_ready;

  // pick one 16-bit quarter of an accumulator
  function automatic logic [WORD_W-1:0] acc_word(input logic [ACC_W-1:0] a,
                                                 input logic [1:0] q);
    acc_word = a[q*WORD_W +: WORD_W];
  endfunction

  // strobe counted once per rising level, so a long strobe is one word
  assign strobe_evt = word_transfer_strobe && !strobe_q; // RULE23

  // the unread extra word of the last store is dropped before a new top
  // word goes in, else the host would take the stale word as its first
  assign buf_out_ready = host_read_ready ||
                         (state == COH_ST_FIRST); // RULE17

  // two-entry path toward the host so a slow reader loses no word
  coh_word_buf u_out_buf (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(buf_in_data),
    .out_valid(out_valid),
    .out_ready(buf_out_ready),
    .out_data(data_out_mux)
  );

  // next state, handshake lines and data path
  always_comb begin
    next_state = state;
    next_pending_instr_reg = pending_instr_reg;
    next_input_data_reg = input_data_reg;
    next_temporary_accumulator = temporary_accumulator;
    next_destination_accumulator = destination_accumulator;
    next_acc_sel = acc_sel;
    next_quarter = quarter;
    next_words_left = words_left;
    next_sync = coproc_ready_sync;
    next_req = more_words_request;
    next_dir = dir_to_memory;
    buf_in_valid = 1'b0;
    buf_in_data = acc_word(destination_accumulator[acc_sel], quarter);
    if (instr_load) next_pending_instr_reg = instr_word;
    if (gr_load) next_input_data_reg = gr_word;
    unique case (state)
      COH_IDLE: begin
        next_sync = 1'b0;
        next_req = 1'b0;
        // decode from the already loaded word, so start lands in a
        // class-specific state on the very next edge
        if (instr_start_strobe &&
            pending_instr_reg[OP_HI:OP_LO] == OP_FLOAT) begin // RULE4
          next_acc_sel = {1'b0, pending_instr_reg[ACSEL_HI:ACSEL_LO]};
          next_quarter = Q_TOP;
          next_words_left = double_precision ? WORDS_DOUBLE
                                             : WORDS_SINGLE; // RULE12
          if (pending_instr_reg[CLASS_HI:CLASS_LO] == CLASS_LOAD) begin
            next_state = COH_LD_WAIT;
            next_dir = 1'b0; // RULE19
            next_sync = 1'b1; // RULE5
            next_req = 1'b1;
          end else if (pending_instr_reg[CLASS_HI:CLASS_LO] ==
                       CLASS_STORE) begin
            next_state = COH_ST_FIRST;
            next_dir = 1'b1; // RULE19
          end
        end
      end
      COH_LD_WAIT: begin
        if (strobe_evt) begin
          // top quarter first, then each lower one
          next_temporary_accumulator[quarter*WORD_W +: WORD_W] =
            load_data; // RULE8 RULE9
          next_quarter = quarter - 2'h1;
          next_words_left = words_left - 3'h1;
          if (words_left == 3'h1) begin
            next_req = 1'b0; // RULE16
            next_sync = 1'b0;
            next_state = COH_LD_MOVE;
          end
        end
      end
      COH_LD_MOVE: begin
        next_destination_accumulator[acc_sel] =
          temporary_accumulator; // RULE11
        next_state = COH_IDLE;
      end
      COH_ST_FIRST: begin
        // phase one: sync up and top word into a drained buffer
        if (!out_valid && buf_in_ready) begin
          buf_in_valid = 1'b1; // RULE13
          next_sync = 1'b1;
          next_req = 1'b1;
          next_quarter = quarter - 2'h1;
          next_words_left = words_left - 3'h1;
          next_state = COH_ST_WAIT;
        end
      end
      COH_ST_WAIT: begin
        // next lower word waits at the buffer input for a strobe
        if (strobe_evt) begin
          buf_in_valid = 1'b1; // RULE15 RULE17
          next_quarter = quarter - 2'h1;
          if (words_left == 3'h0) begin
            next_state = COH_DONE;
          end else begin
            next_words_left = words_left - 3'h1;
            if (words_left == 3'h1) next_req = 1'b0; // RULE16
          end
        end
      end
      COH_DONE: begin
        next_sync = 1'b0;
        next_state = COH_IDLE;
      end
      default: next_state = COH_IDLE;
    endcase
  end

  // registers; init pulse behaves like reset for the major registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= COH_IDLE;
      pending_instr_reg <= WORD_RESET;
      input_data_reg <= WORD_RESET;
      temporary_accumulator <= ACC_RESET;
      for (int i = 0; i < ACC_NUM; i++)
        destination_accumulator[i] <= ACC_RESET;
      acc_sel <= '0;
      quarter <= Q_TOP;
      words_left <= 3'h0;
      coproc_ready_sync <= 1'b0;
      more_words_request <= 1'b0;
      dir_to_memory <= 1'b0;
      strobe_q <= 1'b0;
    end else if (init_pulse) begin // RULE21
      state <= COH_IDLE; // RULE22
      pending_instr_reg <= WORD_RESET;
      input_data_reg <= WORD_RESET;
      temporary_accumulator <= ACC_RESET;
      for (int i = 0; i < ACC_NUM; i++)
        destination_accumulator[i] <= ACC_RESET;
      acc_sel <= '0;
      quarter <= Q_TOP;
      words_left <= 3'h0;
      coproc_ready_sync <= 1'b0;
      more_words_request <= 1'b0;
      dir_to_memory <= 1'b0;
      strobe_q <= word_transfer_strobe;
    end else begin
      state <= next_state;
      pending_instr_reg <= next_pending_instr_reg;
      input_data_reg <= next_input_data_reg;
      temporary_accumulator <= next_temporary_accumulator;
      destination_accumulator <= next_destination_accumulator;
      acc_sel <= next_acc_sel;
      quarter <= next_quarter;
      words_left <= next_words_left;
      coproc_ready_sync <= next_sync;
      more_words_request <= next_req;
      dir_to_memory <= next_dir;
      strobe_q <= word_transfer_strobe;
    end
  end

  assign busy = (state != COH_IDLE);
  assign out_word_q = acc_word(temporary_accumulator, Q_TOP);

  a_init_quiet: assert property ( // RULE22
    @(posedge clk_sys) disable iff (!rst_n)
    init_pulse |=> !coproc_ready_sync && !more_words_request && !busy)
    else $error("init did not quiet handshake");
  a_load_sync_up: assert property ( // RULE5
    @(posedge clk_sys) disable iff (!rst_n)
    state == COH_LD_WAIT && !$past(init_pulse) && $past(state) == COH_IDLE
    |-> coproc_ready_sync && !dir_to_memory)
    else $error("load began without sync");
  a_load_top_word: assert property ( // RULE8
    @(posedge clk_sys) disable iff (!rst_n)
    state == COH_LD_WAIT && strobe_evt && quarter == Q_TOP && !init_pulse
    |=> out_word_q == $past(load_data))
    else $error("first load word not in top quarter");
  a_load_move: assert property ( // RULE11
    @(posedge clk_sys) disable iff (!rst_n)
    state == COH_LD_MOVE && !init_pulse |=> state == COH_IDLE &&
    destination_accumulator[acc_sel] == $past(temporary_accumulator))
    else $error("temporary not moved to destination");
  a_store_first: assert property ( // RULE13
    @(posedge clk_sys) disable iff (!rst_n)
    state == COH_ST_FIRST && !out_valid && !init_pulse
    |=> coproc_ready_sync && dir_to_memory && state == COH_ST_WAIT)
    else $error("store did not raise sync");
  a_strobe_once: assert property ( // RULE23
    @(posedge clk_sys) disable iff (!rst_n)
    state == COH_LD_WAIT && word_transfer_strobe && strobe_q && !init_pulse
    |=> $stable(quarter) && state == COH_LD_WAIT)
    else $error("held strobe counted twice");
  a_req_drop_single: assert property ( // RULE16
    @(posedge clk_sys) disable iff (!rst_n)
    state == COH_LD_WAIT && strobe_evt && words_left == 3'h1 && !init_pulse
    |=> !more_words_request && !coproc_ready_sync && state == COH_LD_MOVE)
    else $error("request not dropped after the last word");
  a_start_words: assert property ( // RULE12
    @(posedge clk_sys) disable iff (!rst_n)
    state == COH_IDLE && instr_start_strobe && !init_pulse &&
    pending_instr_reg[OP_HI:OP_LO] == OP_FLOAT &&
    pending_instr_reg[CLASS_HI:CLASS_LO] == CLASS_LOAD
    |=> more_words_request && words_left ==
    ($past(double_precision) ? WORDS_DOUBLE : WORDS_SINGLE))
    else $error("word count not set by precision");
  a_start_decodes: assert property ( // RULE4
    @(posedge clk_sys) disable iff (!rst_n)
    state == COH_IDLE && instr_start_strobe && !init_pulse &&
    pending_instr_reg[OP_HI:OP_LO] != OP_FLOAT |=> state == COH_IDLE)
    else $error("non floating instruction started");
endmodule

//--- core/coh_pkg.sv
// Purpose: shared constants and types for the operand handshake block
// Assumes: one clock, 16-bit operand words, 64-bit accumulators
// Notes: accumulator quarters are numbered 3 (most significant) down to 0
package coh_pkg;
  localparam int WORD_W = 16;
  localparam int ACC_W = 64;
  localparam int ACC_NUM = 8;
  localparam int ACC_SEL_W = 3;
  localparam int BUF_DEPTH = 2;
  // instruction layout
  localparam int OP_HI = 15;
  localparam int OP_LO = 12;
  localparam logic [3:0] OP_FLOAT = 4'hf; // octal 17
  localparam int CLASS_HI = 11;
  localparam int CLASS_LO = 8;
  localparam logic [3:0] CLASS_LOAD = 4'h7;
  localparam logic [3:0] CLASS_STORE = 4'h6;
  localparam int ACSEL_HI = 7;
  localparam int ACSEL_LO = 6;
  localparam logic [1:0] Q_TOP = 2'h3;
  localparam logic [2:0] WORDS_SINGLE = 3'h2;
  localparam logic [2:0] WORDS_DOUBLE = 3'h4;
  localparam logic [ACC_W-1:0] ACC_RESET = 64'h0;
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0;

  typedef enum logic [5:0] {
    COH_IDLE = 6'h01,
    COH_LD_WAIT = 6'h02,
    COH_LD_MOVE = 6'h04,
    COH_ST_FIRST = 6'h08,
    COH_ST_WAIT = 6'h10,
    COH_DONE = 6'h20
  } coh_state_t;

  typedef struct packed {
    logic valid;
    logic [WORD_W-1:0] data;
  } coh_word_t;
endpackage

//--- core/coh_word_buf.sv
// Purpose: two-entry word buffer with valid/ready on both sides
// Assumes: synchronous use, one write and one read per cycle at most
// Notes: read data comes from a register (head entry)
module coh_word_buf
  import coh_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WORD_W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WORD_W-1:0] out_data
);
  logic [WORD_W-1:0] mem [BUF_DEPTH];
  logic [WORD_W-1:0] next_mem [BUF_DEPTH];
  logic [1:0] count;
  logic [1:0] next_count;
  logic push;
  logic pop;

  // honest full/empty from the count
  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data = mem[0];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // shift register style: entry 0 is always the head
  always_comb begin
    next_mem = mem;
    next_count = count;
    if (pop) begin
      next_mem[0] = mem[1];
    end
    if (push) begin
      if (count == 2'h0 || (count == 2'h1 && pop)) begin
        next_mem[0] = in_data;
      end else begin
        next_mem[pop ? 0 : 1] = in_data;
      end
    end
    next_count = count + 2'(push) - 2'(pop);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mem[0] <= WORD_RESET;
      mem[1] <= WORD_RESET;
      count <= 2'h0;
    end else begin
      mem <= next_mem;
      count <= next_count;
    end
  end

  a_buf_head_holds: assert property ( // RULE14
    @(posedge clk_sys) disable iff (!rst_n)
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("buffer head changed before it was read");
endmodule

//--- verification/coh_host_model.sv
// Purpose: host sequencer model on the far side of the operand handshake
// Assumes: drives on the falling edge, every wait is bounded
// Notes: read pops stall at random to back up the word buffer
module coh_host_model
  import coh_pkg::*;
(
  input wire logic clk_sys,
  input wire logic coproc_ready_sync,
  input wire logic more_words_request,
  input wire logic out_valid,
  input wire logic [WORD_W-1:0] data_out_mux,
  output logic instr_load,
  output logic [WORD_W-1:0] instr_word,
  output logic gr_load,
  output logic [WORD_W-1:0] gr_word,
  output logic instr_start_strobe,
  output logic word_transfer_strobe,
  output logic [WORD_W-1:0] load_data,
  output logic double_precision,
  output logic host_read_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle levels from time zero
  initial begin
    {instr_load, gr_load, instr_start_strobe, word_transfer_strobe} = 4'h0;
    {instr_word, gr_word, load_data} = 48'h0;
    double_precision = 1'b0;
    host_read_ready = 1'b0;
  end
  task automatic tick();
    @(negedge clk_sys);
  endtask
  // saved register first, then instruction, then start
  task automatic issue(input logic [15:0] iw, input logic [15:0] gr,
                       input logic dp);
    gr_word = gr;
    gr_load = 1'b1;
    tick();
    gr_load = 1'b0;
    instr_word = iw;
    instr_load = 1'b1;
    double_precision = dp;
    tick();
    instr_load = 1'b0;
    instr_start_strobe = 1'b1;
    tick();
    instr_start_strobe = 1'b0;
  endtask
  // resample sync until seen, bounded
  task automatic wait_sync(output logic ok);
    int i;
    ok = 1'b0;
    for (i = 0; i < 20 && !ok; i++) begin
      if (coproc_ready_sync === 1'b1) ok = 1'b1;
      else tick();
    end
  endtask
  // strobe and word together, one or two cycles, then branch on request
  task automatic load_words(input logic [63:0] w, output logic [2:0] n);
    logic more;
    n = 3'h0;
    more = 1'b1;
    while (more && n < 3'h5) begin
      load_data = w[63-16*n -: 16];
      word_transfer_strobe = 1'b1;
      // sometimes held two cycles: it must still count as one word
      repeat ($urandom_range(1, 2)) tick();
      word_transfer_strobe = 1'b0;
      load_data = ~load_data; // released line shows no stale word
      tick();
      more = more_words_request;
      n++;
    end
  endtask
  // read the buffer head, request seen with it, then pop
  task automatic pop_word(output logic [15:0] d, output logic r);
    int i;
    for (i = 0; i < 20 && out_valid !== 1'b1; i++) tick();
    repeat ($urandom_range(0, 3)) tick();
    d = data_out_mux;
    r = more_words_request;
    host_read_ready = 1'b1;
    tick();
    host_read_ready = 1'b0;
  endtask
  task automatic store_words(output logic [63:0] w, output logic [2:0] n);
    logic more;
    logic [15:0] d;
    n = 3'h0;
    more = 1'b1;
    w = 64'h0;
    while (more && n < 3'h5) begin
      pop_word(d, more);
      w[63-16*n -: 16] = d;
      word_transfer_strobe = 1'b1;
      tick();
      word_transfer_strobe = 1'b0;
      tick();
      n++;
    end
  endtask
endmodule

//--- verification/coh_handshake_bench.sv
// Purpose: self-checking bench for the operand handshake
// Assumes: accumulators only reachable by loading then storing them
// Notes: lower quarters after a single load are left unchecked
module coh_handshake_bench
  import coh_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic rst_n;
  logic init_pulse;
  logic instr_load, gr_load, instr_start_strobe, word_transfer_strobe;
  logic [WORD_W-1:0] instr_word, gr_word, load_data, data_out_mux;
  logic double_precision, host_read_ready, coproc_ready_sync;
  logic more_words_request, dir_to_memory, out_valid, busy;
  logic [WORD_W-1:0] input_data_reg;
  logic [63:0] acc [4];
  int error_cnt;
  int num_checks;
  always #2.5 clk_sys = ~clk_sys;
  coh_handshake u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .init_pulse(init_pulse), .instr_load(instr_load),
    .instr_word(instr_word), .gr_load(gr_load), .gr_word(gr_word),
    .instr_start_strobe(instr_start_strobe),
    .word_transfer_strobe(word_transfer_strobe), .load_data(load_data),
    .double_precision(double_precision),
    .host_read_ready(host_read_ready),
    .coproc_ready_sync(coproc_ready_sync),
    .more_words_request(more_words_request),
    .dir_to_memory(dir_to_memory), .out_valid(out_valid),
    .data_out_mux(data_out_mux), .input_data_reg(input_data_reg),
    .busy(busy));
  coh_host_model u_host (.clk_sys(clk_sys),
    .coproc_ready_sync(coproc_ready_sync),
    .more_words_request(more_words_request), .out_valid(out_valid),
    .data_out_mux(data_out_mux), .instr_load(instr_load),
    .instr_word(instr_word), .gr_load(gr_load), .gr_word(gr_word),
    .instr_start_strobe(instr_start_strobe),
    .word_transfer_strobe(word_transfer_strobe), .load_data(load_data),
    .double_precision(double_precision),
    .host_read_ready(host_read_ready));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // floating code on top, class, accumulator select, random low bits
  function automatic logic [15:0] mk_instr(input logic [3:0] c, input int a);
    return {OP_FLOAT, c, 2'(a), 6'($urandom)};
  endfunction
  task automatic wait_idle();
    int i;
    for (i = 0; i < 20 && busy !== 1'b0; i++) u_host.tick();
    chk(16'(busy), 16'h0);
  endtask
  task automatic do_load(input int a, input logic dp);
    logic [63:0] w;
    logic [15:0] gr;
    logic [2:0] n;
    logic ok;
    w = {$urandom, $urandom};
    gr = 16'($urandom);
    u_host.issue(mk_instr(CLASS_LOAD, a), gr, dp);
    chk(input_data_reg, gr);
    u_host.tick();
    chk(16'(coproc_ready_sync), 16'h1);
    chk(16'(dir_to_memory), 16'h0);
    u_host.wait_sync(ok);
    u_host.load_words(w, n);
    chk(16'(n), dp ? 16'h4 : 16'h2);
    // expected accumulator contents after the move
    if (dp) acc[a] = w;
    else acc[a][63:32] = w[63:32];
    wait_idle();
  endtask
  task automatic do_store(input int a, input logic dp, input logic xq);
    logic [63:0] g;
    logic [2:0] n;
    logic [15:0] d;
    logic r;
    logic ok;
    int q;
    u_host.issue(mk_instr(CLASS_STORE, a), 16'($urandom), dp);
    u_host.wait_sync(ok);
    chk(16'(ok), 16'h1);
    chk(16'(dir_to_memory), 16'h1);
    u_host.store_words(g, n);
    chk(16'(n), dp ? 16'h4 : 16'h2);
    for (q = 0; q < (dp ? 4 : 2); q++) begin
      chk(g[63-16*q -: 16], acc[a][63-16*q -: 16]);
    end
    u_host.pop_word(d, r);
    if (xq) chk(d, acc[a][31:16]);
    wait_idle();
  endtask
  initial begin
    int a;
    logic ok;
    rst_n = 1'b0;
    init_pulse = 1'b0;
    error_cnt = 0;
    num_checks = 0;
    void'($urandom(32'h6796d06f));
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    chk({12'h0, coproc_ready_sync, more_words_request, busy, out_valid},
        16'h0);
    chk(input_data_reg, WORD_RESET);
    // starts that must be ignored
    u_host.issue({4'he, CLASS_LOAD, 8'h00}, 16'h0, 1'b0);
    u_host.tick();
    chk(16'(busy), 16'h0);
    u_host.issue(mk_instr(4'h5, 0), 16'h0, 1'b0);
    u_host.tick();
    chk(16'(busy), 16'h0);
    $display("test refused done");
    for (a = 0; a < 4; a++) begin
      do_load(a, 1'b1);
      do_store(a, 1'b0, 1'b1);
      do_store(a, 1'b1, 1'b0);
      do_load(a, 1'b0);
      do_store(a, 1'b0, 1'b0);
    end
    $display("test transfers done");
    // initialize in the middle of a load
    u_host.issue(mk_instr(CLASS_LOAD, 1), 16'h1234, 1'b1);
    u_host.wait_sync(ok);
    init_pulse = 1'b1;
    u_host.tick();
    init_pulse = 1'b0;
    chk({13'h0, coproc_ready_sync, more_words_request, busy},
        16'h0);
    $display("test init done");
    give_verdict();
  end
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    error_cnt++;
    give_verdict();
  end
endmodule
